// ==== logic/bsh_pkg.sv ====
// boot strap and host pin package: constants, states and the operation list
// assumes one 50 MHz core clock; all pins reach the core through bsh_boot_strap
// Operation
// - at power-up sample first strap pin as target address bit 4
// - at power-up sample second strap pin as target address bit 5
// - high hardware reset input resets, then configuration reloads from external flash
// - port 1 interrupt is an active-low open-drain output
// - port 2 interrupt is a separate active-low open-drain output
// - address select sets both ports' address and code-share master or slave role
// - boot judges flash contents valid from the serial-input line before loading
// - device is SPI master: drives clock, data out, active-low select; reads data in
// - serial data and clock of both host ports are driven open-drain only
package bsh_pkg;

    // ==========================================================
    // timing
    localparam int CLK_FREQ_MHZ     = 50;
    localparam int STRAP_SETTLE_NS  = 1000;
    localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int SPI_HALF_DIV     = 4;

    // ==========================================================
    // address layout
    localparam int        ADDR_W         = 7;
    localparam int        ADDR_B4_POS    = 4;
    localparam int        ADDR_B5_POS    = 5;
    localparam int        ADDR_SEL_W     = 5;
    localparam int        SEL_SHARE_POS  = 4;
    localparam logic      ADDR_B6_VAL    = 1'b0;
    localparam logic [6:0] ADDR_RST      = 7'h00;

    // ==========================================================
    // flash boot
    localparam logic [7:0] FLASH_CMD_READ = 8'h03;
    localparam logic [7:0] FLASH_MAGIC    = 8'hA5;
    localparam logic [7:0] FLASH_FILL     = 8'h00;
    localparam int         FLASH_ADDR_BYTES = 3;
    localparam int         CFG_BYTES      = 4;

    typedef enum logic [3:0] {
        ST_SETTLE, ST_CAPTURE, ST_CMD, ST_ADDR, ST_SIG, ST_LOAD, ST_DONE, ST_BAD, ST_HOLD
    } bsh_state_e;

endpackage

// ==== logic/bsh_spi_if.sv ====
// byte request carrier between the boot sequencer and the SPI shifter
// assumes both ends run on the same core clock
`timescale 1ns/1ps
interface bsh_spi_if;
    logic       start;
    logic       abort;
    logic [7:0] tx;
    logic       busy;
    logic       done;
    logic [7:0] rx;

    modport ctl (output start, output abort, output tx, input busy, input done, input rx);
    modport eng (input start, input abort, input tx, output busy, output done, output rx);
endinterface

// ==== logic/bsh_spi_shift.sv ====
// SPI mode 0 byte shifter, msb first, clock divided from the core clock
// assumes the select line is owned by the sequencer; data-in is an async pin
`timescale 1ns/1ps
module bsh_spi_shift import bsh_pkg::*; #(
    parameter int HALF_DIV = SPI_HALF_DIV
) (
    input  wire logic clk,
    input  wire logic resetn,
    bsh_spi_if.eng    bus,
    input  wire logic miso_pin,
    output logic      sclk,
    output logic      mosi
);

    // slack: synced data-in lags two cycles, so half period must exceed that
    if (HALF_DIV < 3) begin : g_bad_div
        $error("HALF_DIV must be at least 3");
    end

    localparam int DW = $clog2(HALF_DIV);

    logic [1:0]    miso_sync_q;
    logic [DW-1:0] div_q;
    logic [2:0]    bit_q;
    logic [7:0]    sh_q;
    logic [7:0]    rx_q;
    logic          busy_q;
    logic          done_q;
    logic          sclk_q;
    logic          mosi_q;

    wire half_tick = busy_q && (div_q == DW'(HALF_DIV - 1));

    // ==========================================================
    // shifter
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            miso_sync_q <= 2'h0;
            div_q       <= '0;
            bit_q       <= 3'h0;
            sh_q        <= 8'h00;
            rx_q        <= 8'h00;
            busy_q      <= 1'b0;
            done_q      <= 1'b0;
            sclk_q      <= 1'b0;
            mosi_q      <= 1'b0;
        end else begin
            miso_sync_q <= {miso_sync_q[0], miso_pin};
            done_q      <= 1'b0;
            if (bus.abort) begin
                busy_q <= 1'b0;
                sclk_q <= 1'b0;
            end else if (bus.start && !busy_q) begin
                sh_q   <= bus.tx;
                mosi_q <= bus.tx[7];
                busy_q <= 1'b1;
                bit_q  <= 3'h0;
                div_q  <= '0;
            end else if (busy_q) begin
                div_q <= half_tick ? '0 : div_q + DW'(1);
                if (half_tick && !sclk_q) begin
                    sclk_q <= 1'b1;
                    rx_q   <= {rx_q[6:0], miso_sync_q[1]};
                end else if (half_tick) begin
                    sclk_q <= 1'b0;
                    sh_q   <= {sh_q[6:0], 1'b0};
                    mosi_q <= sh_q[6];
                    bit_q  <= bit_q + 3'h1;
                    if (bit_q == 3'h7) begin
                        busy_q <= 1'b0;
                        done_q <= 1'b1;
                    end
                end
            end
        end
    end

    assign bus.busy = busy_q;
    assign bus.done = done_q;
    assign bus.rx   = rx_q;
    assign sclk     = sclk_q;
    assign mosi     = mosi_q;

endmodule // bsh_spi_shift

// ==== logic/bsh_boot_strap.sv ====
// power-up strap capture, flash boot loader and host pin control
// assumes an I2C engine on the same clock asks for pin drives and raises irq requests
`timescale 1ns/1ps
module bsh_boot_strap import bsh_pkg::*; #(
    parameter int NCFG     = CFG_BYTES,
    parameter int HALF_DIV = SPI_HALF_DIV
) (
    input  wire logic                  clk,
    input  wire logic                  resetn,
    input  wire logic                  addr_strap_bit4_pin,
    input  wire logic                  addr_strap_bit5_pin,
    input  wire logic [ADDR_SEL_W-1:0] addr_sel_code,
    input  wire logic                  hw_reload_reset_in,
    input  wire logic                  flash_miso,
    output logic                       flash_sclk,
    output logic                       flash_mosi,
    output logic                       flash_select_n,
    input  wire logic                  host1_serial_data_i,
    output logic                       host1_serial_data_o,
    output logic                       host1_serial_data_oe_n,
    input  wire logic                  host1_serial_clock_i,
    output logic                       host1_serial_clock_o,
    output logic                       host1_serial_clock_oe_n,
    input  wire logic                  host2_serial_data_i,
    output logic                       host2_serial_data_o,
    output logic                       host2_serial_data_oe_n,
    input  wire logic                  host2_serial_clock_i,
    output logic                       host2_serial_clock_o,
    output logic                       host2_serial_clock_oe_n,
    output logic                       host1_irq_n_o,
    output logic                       host1_irq_n_oe_n,
    output logic                       host2_irq_n_o,
    output logic                       host2_irq_n_oe_n,
    input  wire logic [3:0]            i2c_drive_low,
    output logic [3:0]                 i2c_line_sync,
    input  wire logic [1:0]            irq_req,
    output logic [ADDR_W-1:0]          target_addr,
    output logic                       code_share_master,
    output logic                       addr_fixed,
    output logic                       i2c_enable,
    output logic                       flash_valid,
    output logic                       boot_done,
    output logic [8*NCFG-1:0]          cfg_data
);

    // byte index is 8 bits wide, so the slice used for cfg writes caps the count
    if (NCFG < 1 || NCFG > 255) begin : g_bad_ncfg
        $error("NCFG must be 1..255");
    end

    localparam int SW = $clog2(STRAP_SETTLE_CYC + 1);

    function automatic logic is_xfer(input bsh_state_e s);
        is_xfer = (s == ST_CMD) || (s == ST_ADDR) || (s == ST_SIG) || (s == ST_LOAD);
    endfunction

    // ==========================================================
    // pin synchronisers
    logic [1:0]            s4_sync_q, s5_sync_q, rl_sync_q;
    logic [ADDR_SEL_W-1:0] sel_m_q, sel_s_q;
    wire                   s4_s = s4_sync_q[1];
    wire                   s5_s = s5_sync_q[1];
    wire                   rl_s = rl_sync_q[1];

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s4_sync_q <= 2'h0;
            s5_sync_q <= 2'h0;
            rl_sync_q <= 2'h0;
            sel_m_q   <= '0;
            sel_s_q   <= '0;
        end else begin
            s4_sync_q <= {s4_sync_q[0], addr_strap_bit4_pin};
            s5_sync_q <= {s5_sync_q[0], addr_strap_bit5_pin};
            rl_sync_q <= {rl_sync_q[0], hw_reload_reset_in};
            sel_m_q   <= addr_sel_code;
            sel_s_q   <= sel_m_q;
        end
    end

    // ==========================================================
    // boot sequencer
    bsh_spi_if spi ();

    bsh_spi_shift #(.HALF_DIV(HALF_DIV)) u_shift (
        .clk      (clk),
        .resetn   (resetn),
        .bus      (spi.eng),
        .miso_pin (flash_miso),
        .sclk     (flash_sclk),
        .mosi     (flash_mosi)
    );

    bsh_state_e        st_q, st_d;
    logic [SW-1:0]     settle_q;
    logic [7:0]        idx_q;
    logic              pend_q;
    logic              sel_n_q;
    logic [6:0]        addr_q;
    logic              share_q, fixed_q, valid_q, done_q;
    logic [8*NCFG-1:0] cfg_q;

    wire last_addr = idx_q == 8'(FLASH_ADDR_BYTES - 1);
    wire last_cfg  = idx_q == 8'(NCFG - 1);
    wire sig_ok    = spi.rx == FLASH_MAGIC;

    assign spi.start = is_xfer(st_q) && !pend_q && !spi.busy && !rl_s;
    assign spi.abort = rl_s;
    assign spi.tx    = (st_q == ST_CMD) ? FLASH_CMD_READ : FLASH_FILL;

    always_comb begin
        st_d = st_q;
        if (rl_s) begin
            st_d = ST_HOLD;
        end else begin
            case (st_q)
                ST_SETTLE:  if (settle_q == SW'(STRAP_SETTLE_CYC)) st_d = ST_CAPTURE;
                ST_CAPTURE: st_d = ST_CMD;
                ST_CMD:     if (spi.done) st_d = ST_ADDR;
                ST_ADDR:    if (spi.done && last_addr) st_d = ST_SIG;
                ST_SIG:     if (spi.done) st_d = sig_ok ? ST_LOAD : ST_BAD;
                ST_LOAD:    if (spi.done && last_cfg) st_d = ST_DONE;
                ST_HOLD:    st_d = fixed_q ? ST_CMD : ST_SETTLE;
                default:    st_d = st_q;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q     <= ST_SETTLE;
            settle_q <= '0;
            idx_q    <= 8'h00;
            pend_q   <= 1'b0;
            sel_n_q  <= 1'b1;
            addr_q   <= ADDR_RST;
            share_q  <= 1'b0;
            fixed_q  <= 1'b0;
            valid_q  <= 1'b0;
            done_q   <= 1'b0;
            cfg_q    <= '0;
        end else begin
            st_q    <= st_d;
            sel_n_q <= !is_xfer(st_d);
            if (st_q == ST_SETTLE && settle_q != SW'(STRAP_SETTLE_CYC)) begin
                settle_q <= settle_q + SW'(1);
            end
            if (spi.start) begin
                pend_q <= 1'b1;
            end else if (spi.done || rl_s) begin
                pend_q <= 1'b0;
            end
            if (st_d != st_q) begin
                idx_q <= 8'h00;
            end else if (spi.done) begin
                idx_q <= idx_q + 8'h01;
            end
            // straps held only from power-up, a reload keeps them
            if (st_q == ST_CAPTURE) begin
                addr_q  <= {ADDR_B6_VAL, s5_s, s4_s, sel_s_q[3:0]};
                share_q <= sel_s_q[SEL_SHARE_POS];
                fixed_q <= 1'b1;
            end
            if (st_q == ST_LOAD && spi.done) begin
                cfg_q[8*idx_q[$clog2(NCFG+1)-1:0] +: 8] <= spi.rx;
            end
            if (st_q == ST_SIG && spi.done) begin
                valid_q <= sig_ok;
            end
            if (rl_s) begin
                valid_q <= 1'b0;
                done_q  <= 1'b0;
                cfg_q   <= '0;
            end else if (st_d == ST_DONE) begin
                done_q <= 1'b1;
            end
        end
    end

    // ==========================================================
    // host pins, open drain: output value is always low, enable low drives
    logic [3:0] ln_m_q, ln_s_q, od_oe_n_q;
    logic [1:0] irq_oe_n_q;
    wire  [3:0] ln_pin = {host2_serial_clock_i, host2_serial_data_i, host1_serial_clock_i, host1_serial_data_i};
    wire        talk   = fixed_q && !rl_s;

    for (genvar i = 0; i < 4; i++) begin : g_line
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                ln_m_q[i]    <= 1'b1;
                ln_s_q[i]    <= 1'b1;
                od_oe_n_q[i] <= 1'b1;
            end else begin
                ln_m_q[i]    <= ln_pin[i];
                ln_s_q[i]    <= ln_m_q[i];
                od_oe_n_q[i] <= !(i2c_drive_low[i] && talk);
            end
        end
    end

    for (genvar p = 0; p < 2; p++) begin : g_irq
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                irq_oe_n_q[p] <= 1'b1;
            end else begin
                irq_oe_n_q[p] <= !irq_req[p];
            end
        end
    end

    logic zero_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            zero_q <= 1'b0;
        end else begin
            zero_q <= 1'b0;
        end
    end

    assign host1_serial_data_o     = zero_q;
    assign host1_serial_clock_o    = zero_q;
    assign host2_serial_data_o     = zero_q;
    assign host2_serial_clock_o    = zero_q;
    assign host1_irq_n_o           = zero_q;
    assign host2_irq_n_o           = zero_q;
    assign host1_serial_data_oe_n  = od_oe_n_q[0];
    assign host1_serial_clock_oe_n = od_oe_n_q[1];
    assign host2_serial_data_oe_n  = od_oe_n_q[2];
    assign host2_serial_clock_oe_n = od_oe_n_q[3];
    assign host1_irq_n_oe_n        = irq_oe_n_q[0];
    assign host2_irq_n_oe_n        = irq_oe_n_q[1];
    assign i2c_line_sync           = ln_s_q;
    assign flash_select_n          = sel_n_q;
    assign target_addr             = addr_q;
    assign code_share_master       = share_q;
    assign addr_fixed              = fixed_q;
    assign flash_valid             = valid_q;
    assign boot_done               = done_q;
    assign cfg_data                = cfg_q;

    logic en_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            en_q <= 1'b0;
        end else begin
            en_q <= talk;
        end
    end
    assign i2c_enable = en_q;

    // ==========================================================
    // checks
    AST_ADDR_B4: assert property (@(posedge clk) disable iff (!resetn)
        $rose(fixed_q) |-> addr_q[ADDR_B4_POS] == $past(s4_s)) else $error("address bit 4 not from strap");
    AST_ADDR_B5: assert property (@(posedge clk) disable iff (!resetn)
        $rose(fixed_q) |-> addr_q[ADDR_B5_POS] == $past(s5_s)) else $error("address bit 5 not from strap");
    AST_RELOAD_HOLD: assert property (@(posedge clk) disable iff (!resetn)
        rl_s |=> st_q == ST_HOLD && !done_q && !valid_q) else $error("reload did not hold boot");
    AST_RELOAD_RESUME: assert property (@(posedge clk) disable iff (!resetn)
        st_q == ST_HOLD && fixed_q && !rl_s |=> st_q == ST_CMD ##1 !sel_n_q) else $error("no flash reload");
    AST_IRQ1: assert property (@(posedge clk) disable iff (!resetn)
        irq_req[0] |=> !host1_irq_n_oe_n && !host1_irq_n_o) else $error("port 1 irq not driven low");
    AST_IRQ2: assert property (@(posedge clk) disable iff (!resetn)
        !irq_req[1] |=> host2_irq_n_oe_n) else $error("port 2 irq driven without request");
    AST_SEL_ROLE: assert property (@(posedge clk) disable iff (!resetn)
        $rose(fixed_q) |-> share_q == $past(sel_s_q[SEL_SHARE_POS]) && addr_q[3:0] == $past(sel_s_q[3:0]))
        else $error("address select not applied");
    AST_SIG_BAD: assert property (@(posedge clk) disable iff (!resetn)
        st_q == ST_SIG && spi.done && !sig_ok && !rl_s |=> st_q == ST_BAD && !valid_q ##1 sel_n_q)
        else $error("invalid flash not rejected");
    AST_SCLK_SEL: assert property (@(posedge clk) disable iff (!resetn)
        $rose(flash_sclk) |-> !flash_select_n) else $error("flash clock without select");
    AST_OD_DRIVE: assert property (@(posedge clk) disable iff (!resetn)
        !od_oe_n_q[0] |-> $past(i2c_drive_low[0]) && !host1_serial_data_o) else $error("bad open-drain drive");
    AST_QUIET: assert property (@(posedge clk) disable iff (!resetn)
        !fixed_q |-> od_oe_n_q == 4'hF && !en_q) else $error("host port active before address fixed");

    COV_BOOT_OK: cover property (@(posedge clk) disable iff (!resetn) $rose(done_q) && valid_q);
    COV_BOOT_BAD: cover property (@(posedge clk) disable iff (!resetn) st_q == ST_BAD);
    COV_RELOAD: cover property (@(posedge clk) disable iff (!resetn) st_q == ST_HOLD ##1 st_q == ST_CMD);

endmodule // bsh_boot_strap

// ==== tb/bsh_flash_model.sv ====
// behavioural SPI mode 0 flash answering one read frame from a byte image
// assumes the device owns clock and select; image byte 0 is the signature
`timescale 1ns/1ps
module bsh_flash_model (
    input  wire logic        sclk,
    input  wire logic        mosi,
    input  wire logic        sel_n,
    input  wire logic [39:0] image,
    output logic             miso,
    output logic [31:0]      head
);
    int          bc;
    logic        out_q = 1'b0;
    logic [31:0] head_q = 32'h0;

    // ==========================================================
    // command and address capture, msb first
    always @(posedge sclk or posedge sel_n) begin
        if (sel_n) begin
            bc <= 0;
        end else begin
            if (bc < 32) head_q <= {head_q[30:0], mosi};
            bc <= bc + 1;
        end
    end

    assign head = head_q;

    // ==========================================================
    // data out changes on the falling edge, valid before the next rise
    always @(negedge sclk) begin
        if (!sel_n && bc >= 32 && bc < 72) out_q <= image[8 * ((bc - 32) / 8) + 7 - (bc - 32) % 8];
    end

    // released line shows the inverse so a stale sample cannot look right
    assign miso = sel_n ? ~out_q : out_q;
endmodule // bsh_flash_model

// ==== tb/tb_boot_strap_host_pins.sv ====
// self-checking bench: strap capture, flash boot, reload and host pins
// assumes bsh_pkg and the flash model; host lines have pull-ups in the bench
`timescale 1ns/1ps
module tb_boot_strap_host_pins;
    import bsh_pkg::*;
    logic        clk = 1'b0, resetn = 1'b0, s4 = 1'b0, s5 = 1'b0, reload = 1'b0;
    logic [4:0]  sel = 5'h00;
    logic [3:0]  dl = 4'h0, ext = 4'h0, oe_n, pin_o, pin_i, sync;
    logic [1:0]  iq = 2'h0, irq_o, irq_oe_n;
    logic [39:0] image = 40'h0;
    logic [31:0] head, cfg;
    logic [6:0]  addr, prev_addr;
    logic        miso, sclk, mosi, sel_n, csm, fixed, en, fvalid, bdone;
    int          fail_count = 0, n_checks = 0, i, r;

    always #10 clk = ~clk;
    assign pin_i = oe_n & ~ext;

    bsh_boot_strap uut (.clk(clk), .resetn(resetn), .addr_strap_bit4_pin(s4), .addr_strap_bit5_pin(s5),
        .addr_sel_code(sel), .hw_reload_reset_in(reload), .flash_miso(miso), .flash_sclk(sclk),
        .flash_mosi(mosi), .flash_select_n(sel_n),
        .host1_serial_data_i(pin_i[0]), .host1_serial_data_o(pin_o[0]), .host1_serial_data_oe_n(oe_n[0]),
        .host1_serial_clock_i(pin_i[1]), .host1_serial_clock_o(pin_o[1]), .host1_serial_clock_oe_n(oe_n[1]),
        .host2_serial_data_i(pin_i[2]), .host2_serial_data_o(pin_o[2]), .host2_serial_data_oe_n(oe_n[2]),
        .host2_serial_clock_i(pin_i[3]), .host2_serial_clock_o(pin_o[3]), .host2_serial_clock_oe_n(oe_n[3]),
        .host1_irq_n_o(irq_o[0]), .host1_irq_n_oe_n(irq_oe_n[0]), .host2_irq_n_o(irq_o[1]),
        .host2_irq_n_oe_n(irq_oe_n[1]), .i2c_drive_low(dl), .i2c_line_sync(sync), .irq_req(iq),
        .target_addr(addr), .code_share_master(csm), .addr_fixed(fixed), .i2c_enable(en),
        .flash_valid(fvalid), .boot_done(bdone), .cfg_data(cfg));

    bsh_flash_model flash (.sclk(sclk), .mosi(mosi), .sel_n(sel_n), .image(image), .miso(miso), .head(head));

    // ==========================================================
    // helpers
    task automatic step();
        @(posedge clk);
        #2;
    endtask

    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [6:0] exp_addr(logic b5, logic b4, logic [4:0] code);
        return {ADDR_B6_VAL, b5, b4, code[3:0]};
    endfunction

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        void'($urandom(74764));
        for (r = 0; r < 2; r++) begin
            step();
            resetn = 1'b0;
            {s5, s4, sel} = (r == 1) ? 7'h7F : 7'($urandom);
            image = {8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom), FLASH_MAGIC};
            dl = 4'hF;
            iq = 2'h1;
            repeat (2) @(posedge clk);
            #2 resetn = 1'b1;
            // irq is not gated by the address fix; it follows one edge later
            step();
            chk("irq before fix", {30'h0, irq_oe_n}, 32'h2);
            for (i = 0; i < 200 && fixed !== 1'b1; i++) begin
                chk("silent pins", {28'h0, oe_n}, 32'hF);
                step();
            end
            chk("strap addr", {25'h0, addr}, {25'h0, exp_addr(s5, s4, sel)});
            chk("share role", {31'h0, csm}, {31'h0, sel[SEL_SHARE_POS]});
            chk("addr fixed", {31'h0, fixed}, 32'h1);
            if (r == 1) begin
                // cut the frame mid-byte: select must rise and clock drop, boot restarts
                repeat (100) step();
                reload = 1'b1;
                repeat (4) step();
                chk("cut select", {31'h0, sel_n}, 32'h1);
                chk("cut clock", {31'h0, sclk}, 32'h0);
                reload = 1'b0;
            end
            for (i = 0; i < 3000 && bdone !== 1'b1; i++) step();
            step();
            chk("flash head", head, {FLASH_CMD_READ, 24'h000000});
            chk("enable", {31'h0, en}, 32'h1);
            chk("valid", {31'h0, fvalid}, 32'h1);
            chk("cfg", cfg, image[39:8]);
            chk("select idle", {31'h0, sel_n}, 32'h1);

            // random pin traffic with an external party pulling some lines low
            for (i = 0; i < 16; i++) begin
                dl = (i == 0) ? 4'hF : 4'($urandom);
                iq = 2'($urandom);
                ext = 4'($urandom);
                step();
                chk("irq oe", {30'h0, irq_oe_n}, {30'h0, ~iq});
                chk("irq data", {30'h0, irq_o}, 32'h0);
                repeat (2) step();
                chk("line oe", {28'h0, oe_n}, {28'h0, ~dl});
                chk("line data", {28'h0, pin_o}, 32'h0);
                chk("line sync", {28'h0, sync}, {28'h0, ~dl & ~ext});
            end

            // reload with a corrupted image: strap bit 4 moves but must not be taken
            prev_addr = addr;
            ext = 4'h0;
            dl = 4'hF;
            s4 = ~s4;
            image[7:0] = (r == 0) ? 8'h5A : 8'h00;
            reload = 1'b1;
            repeat (5) step();
            chk("reload select", {31'h0, sel_n}, 32'h1);
            chk("reload flags", {30'h0, fvalid, bdone}, 32'h0);
            chk("reload pins", {28'h0, oe_n}, 32'hF);
            chk("reload enable", {31'h0, en}, 32'h0);
            reload = 1'b0;
            for (i = 0; i < 50 && sel_n !== 1'b0; i++) step();
            chk("reboot starts", {31'h0, sel_n}, 32'h0);
            for (i = 0; i < 3000 && sel_n !== 1'b1; i++) step();
            step();
            chk("bad image", {30'h0, fvalid, bdone}, 32'h0);
            chk("addr kept", {25'h0, addr}, {25'h0, prev_addr});
        end
        results();
    end

    // ==========================================================
    // watchdog: whole run is under four thousand cycles, limit is ten thousand
    initial begin
        #200_000;
        fail_count++;
        results();
    end
endmodule // tb_boot_strap_host_pins
